// *** logic/scfg_consts.svh ***
// Purpose: Offsets, field positions and reset values of the config bank
// Assumes: Byte addresses on the register port
// Notes:   Definitions only
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define SCFG_OFF_PRIO        8'h48
`define SCFG_OFF_LINE        8'h4c
`define SCFG_OFF_MEMBASE     8'h50

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCFG_PRIO_LSB        22
`define SCFG_PRIO_MSB        30
`define SCFG_LINE_LSB        2
`define SCFG_LINE_MSB        5
`define SCFG_LAT_LSB         8
`define SCFG_LAT_MSB         15
`define SCFG_BASE_LSB        12

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SCFG_PRIO_RST        9'h001
`define SCFG_LINE_RST        4'h0
`define SCFG_LAT_RST_CONV    8'h00
`define SCFG_LAT_RST_EXT     8'h40
`define SCFG_HDR_CFG_RST     7'h00
`define SCFG_BASE_RST        20'h00000

`endif

// *** logic/scfg_pkg.sv ***
// Purpose: Shared types for the secondary config bank
// Assumes: Nothing
// Notes:   Constants live in scfg_consts.svh
package scfg_pkg;
  typedef enum logic [2:0] {
    SCFG_WIN_MISS = 3'b001,
    SCFG_WIN_CSR  = 3'b010,
    SCFG_WIN_FWD  = 3'b100
  } scfg_win_t;

  typedef struct packed {
    logic [31:0] hit_addr;
    logic [31:0] fwd_addr;
    scfg_win_t   kind;
  } scfg_dec_t;
endpackage

// *** logic/scfg_reg_file.sv ***
// Purpose: Writable storage of the secondary config bank
// Assumes: Write strobe already decoded per register
// Notes:   Read-only bits are not stored
`timescale 1ns/1ps
`include "scfg_consts.svh"
module scfg_reg_file
  import scfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // Mode
  input  wire logic        fwd_bridge_i,
  input  wire logic        ext_mode_i,
  input  wire logic [19:0] setup_i,
  // Writes
  input  wire logic        wr_prio_i,
  input  wire logic        wr_line_i,
  input  wire logic        wr_base_i,
  input  wire logic [31:0] wdata_i,
  // State
  output logic [8:0]       prio_o,
  output logic [3:0]       line_o,
  output logic [7:0]       lat_o,
  output logic [19:0]      base_o
);
  logic [8:0]  prio_reg, prio_next;
  logic [3:0]  line_reg, line_next;
  logic [7:0]  lat_reg,  lat_next;
  logic [19:0] base_reg, base_next;

  always_comb begin
    prio_next = prio_reg;
    line_next = line_reg;
    lat_next  = lat_reg;
    base_next = base_reg & setup_i;
    if (ce_i && wr_prio_i) begin
      prio_next = wdata_i[`SCFG_PRIO_MSB:`SCFG_PRIO_LSB];
    end
    if (ce_i && wr_line_i) begin
      line_next = wdata_i[`SCFG_LINE_MSB:`SCFG_LINE_LSB];
      if (fwd_bridge_i) begin
        lat_next = wdata_i[`SCFG_LAT_MSB:`SCFG_LAT_LSB];
      end
    end
    if (!fwd_bridge_i) begin
      lat_next = `SCFG_LAT_RST_CONV;
    end
    if (ce_i && wr_base_i) begin
      base_next = wdata_i[31:`SCFG_BASE_LSB] & setup_i;
    end
    if (!ce_i) begin
      base_next = base_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prio_reg <= `SCFG_PRIO_RST;
      line_reg <= `SCFG_LINE_RST;
      lat_reg  <= (fwd_bridge_i && ext_mode_i) ? `SCFG_LAT_RST_EXT
                                               : `SCFG_LAT_RST_CONV;
      base_reg <= `SCFG_BASE_RST;
    end else if (ce_i) begin
      prio_reg <= prio_next;
      line_reg <= line_next;
      lat_reg  <= lat_next;
      base_reg <= base_next;
    end
  end

  assign prio_o = prio_reg;
  assign line_o = line_reg;
  assign lat_o  = lat_reg;
  assign base_o = base_reg;
endmodule

// *** logic/scfg_regs.sv ***
// How it works
// - Bits 22..30 at 0x48 are writable priorities, bridge then masters.
// - Bridge priority resets to one, masters to zero, bit 31 reads zero.
// - Line size bits 2..5 are writable for 4/8/16/32 dwords, reset zero.
// - Line size bits 1:0 and 7:6 read zero.
// - The latency timer is read-only zero in reverse bridge mode.
// - Forward mode timer is writable, reset 0x00 or 0x40 if extended.
// - Header type bits 31:16 read zero.
// - Base register bits 0, 2:1 and 11:4 read zero.
// - Base bit 3 reads zero, non-prefetchable.
// - Base bits 31:12 reset zero, writable where setup bits 30:12 are one; bit 31 is writable whenever any of setup bits 31:12 is one.
// - Window size and enable come from the upstream setup register input; the type bits are fixed.
// - The window spans 4KB up to 2GB.
// - Hits in the lowest 4KB go to the device's own registers.
//
// Purpose: Secondary side configuration registers and memory window decode
// Assumes: Strap and setup inputs are synchronous to clk_i
// Notes:   Read data is valid only in the cycle after the read strobe
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "scfg_consts.svh"
module scfg_regs
  import scfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // Mode and upstream setup
  input  wire logic        fwd_bridge_i,
  input  wire logic        ext_mode_i,
  input  wire logic [31:0] mem0_setup_i,
  input  wire logic [31:0] mem0_xlat_i,
  // Memory access decode
  input  wire logic [31:0] mem_addr_i,
  input  wire logic        mem_valid_i,
  output logic             csr_hit_o,
  output logic             fwd_hit_o,
  output logic [31:0]      fwd_addr_o,
  // Register state to the arbiter and bus logic
  output logic [8:0]       prio_o,
  output logic [3:0]       line_size_o,
  output logic [7:0]       lat_timer_o
);
  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic        wr_prio, wr_line, wr_base;
  logic [19:0] setup_win;
  logic [8:0]  prio;
  logic [3:0]  line;
  logic [7:0]  lat;
  logic [19:0] base;

  always_comb begin
    wr_prio = wr_i && hit(addr_i, `SCFG_OFF_PRIO);
    wr_line = wr_i && hit(addr_i, `SCFG_OFF_LINE);
    wr_base = wr_i && hit(addr_i, `SCFG_OFF_MEMBASE);
    // Keep the window between 4KB and 2GB
    setup_win = {1'b1, mem0_setup_i[30:`SCFG_BASE_LSB]};
    if (mem0_setup_i[31:`SCFG_BASE_LSB] == 20'h00000) begin
      setup_win = 20'h00000;
    end
  end

  scfg_reg_file u_file (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .ce_i         (ce_i),
    .fwd_bridge_i (fwd_bridge_i),
    .ext_mode_i   (ext_mode_i),
    .setup_i      (setup_win),
    .wr_prio_i    (wr_prio),
    .wr_line_i    (wr_line),
    .wr_base_i    (wr_base),
    .wdata_i      (wdata_i),
    .prio_o       (prio),
    .line_o       (line),
    .lat_o        (lat),
    .base_o       (base)
  );

  // ---------------------------------------------------------------
  // Window decode
  // ---------------------------------------------------------------
  scfg_win_if w ();
  assign w.base  = base;
  assign w.setup = setup_win;
  assign w.xlat  = mem0_xlat_i[31:`SCFG_BASE_LSB];
  assign w.addr  = mem_addr_i;
  assign w.valid = mem_valid_i;

  scfg_win_dec u_dec (
    .w (w)
  );

  // ---------------------------------------------------------------
  // Read mux and output registers
  // ---------------------------------------------------------------
  logic [31:0] rdata_reg, rdata_next;
  logic        csr_reg, csr_next;
  logic        fwd_reg, fwd_next;
  logic [31:0] fa_reg, fa_next;
  logic [8:0]  prio_reg, prio_next;
  logic [3:0]  line_reg, line_next;
  logic [7:0]  lat_reg, lat_next;

  always_comb begin
    rdata_next = 32'h00000000;
    if (ce_i && rd_i) begin
      case (1'b1)
        hit(addr_i, `SCFG_OFF_PRIO):
          rdata_next = {1'b0, prio, 22'h000000};
        hit(addr_i, `SCFG_OFF_LINE):
          rdata_next = {8'h00, 1'b0, `SCFG_HDR_CFG_RST, lat,
                        2'b00, line, 2'b00};
        hit(addr_i, `SCFG_OFF_MEMBASE):
          rdata_next = {base, 8'h00, 1'b0, 2'b00, 1'b0};
        default:
          rdata_next = 32'h00000000;
      endcase
    end else if (!ce_i) begin
      rdata_next = rdata_reg;
    end
    csr_next  = (w.kind == SCFG_WIN_CSR);
    fwd_next  = (w.kind == SCFG_WIN_FWD);
    fa_next   = w.fwd_addr;
    prio_next = prio;
    line_next = line;
    lat_next  = lat;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h00000000;
      csr_reg   <= 1'b0;
      fwd_reg   <= 1'b0;
      fa_reg    <= 32'h00000000;
      prio_reg  <= `SCFG_PRIO_RST;
      line_reg  <= `SCFG_LINE_RST;
      lat_reg   <= `SCFG_LAT_RST_CONV;
    end else if (ce_i) begin
      rdata_reg <= rdata_next;
      csr_reg   <= csr_next;
      fwd_reg   <= fwd_next;
      fa_reg    <= fa_next;
      prio_reg  <= prio_next;
      line_reg  <= line_next;
      lat_reg   <= lat_next;
    end
  end

  assign rdata_o     = rdata_reg;
  assign csr_hit_o   = csr_reg;
  assign fwd_hit_o   = fwd_reg;
  assign fwd_addr_o  = fa_reg;
  assign prio_o      = prio_reg;
  assign line_size_o = line_reg;
  assign lat_timer_o = lat_reg;
endmodule

// *** logic/scfg_win_dec.sv ***
// Purpose: Window hit decode and upstream address translation
// Assumes: Setup mask bits are ones for the decoded upper address bits
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "scfg_consts.svh"
module scfg_win_dec
  import scfg_pkg::*;
(
  scfg_win_if.dec w
);
  logic [19:0] pg;
  logic        hit;
  logic        low_page;

  always_comb begin
    pg       = w.addr[31:`SCFG_BASE_LSB];
    hit      = w.valid && (w.setup != 20'h00000) &&
               ((pg & w.setup) == (w.base & w.setup));
    low_page = ((pg & ~w.setup) == 20'h00000);
    if (!hit) begin
      w.kind = SCFG_WIN_MISS;
    end else if (low_page) begin
      w.kind = SCFG_WIN_CSR;
    end else begin
      w.kind = SCFG_WIN_FWD;
    end
    // Translated base replaces the decoded upper bits
    w.fwd_addr = {(w.xlat & w.setup) | (pg & ~w.setup),
                  w.addr[`SCFG_BASE_LSB-1:0]};
  end
endmodule

// *** logic/scfg_win_if.sv ***
// Purpose: Carries window setup and decoded results between modules
// Assumes: One clock domain
// Notes:   Used only inside the bank
`timescale 1ns/1ps
interface scfg_win_if;
  import scfg_pkg::*;
  logic [19:0] base;
  logic [19:0] setup;
  logic [19:0] xlat;
  logic [31:0] addr;
  logic        valid;
  scfg_win_t   kind;
  logic [31:0] fwd_addr;

  modport bank (output base, setup, xlat, addr, valid,
                input  kind, fwd_addr);
  modport dec  (input  base, setup, xlat, addr, valid,
                output kind, fwd_addr);
endinterface

// *** verif/scfg_regs_assertions.sv ***
// Purpose: Port checks for scfg_regs
// Assumes: ce_i high while checked
// Notes:   Bound from the bench
`timescale 1ns/1ps
module scfg_regs_assertions (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  // Register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Mode and decode
  input wire logic        fwd_bridge_i,
  input wire logic [31:0] mem0_setup_i,
  input wire logic        mem_valid_i,
  input wire logic        csr_hit_o,
  input wire logic        fwd_hit_o,
  input wire logic [7:0]  lat_timer_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire r48 = rd_i && ce_i && addr_i[7:2] == 6'h12;
  wire r4c = rd_i && ce_i && addr_i[7:2] == 6'h13;
  wire r50 = rd_i && ce_i && addr_i[7:2] == 6'h14;
  wire w48 = wr_i && ce_i && addr_i[7:2] == 6'h12;

  property p_prio_rsv; r48 |=> rdata_o[31] == 1'b0; endproperty
  a_prio_rsv: assert property (p_prio_rsv)
    else $error("priority bit 31 not zero");
  property p_prio_wr;
    w48 ##1 r48 |=> rdata_o[30:22] == $past(wdata_i[30:22], 2);
  endproperty
  a_prio_wr: assert property (p_prio_wr)
    else $error("priority bits lost write");
  property p_line_rsv;
    r4c |=> rdata_o[1:0] == 2'h0 && rdata_o[7:6] == 2'h0;
  endproperty
  a_line_rsv: assert property (p_line_rsv)
    else $error("line size reserved bits set");
  property p_hdr; r4c |=> rdata_o[31:16] == 16'h0000; endproperty
  a_hdr: assert property (p_hdr)
    else $error("header kind not zero");
  property p_rev; r4c && !fwd_bridge_i |=> rdata_o[15:8] == 8'h00;
  endproperty
  a_rev: assert property (p_rev)
    else $error("timer nonzero in reverse mode");
  property p_rev_out; (!fwd_bridge_i)[*3] |-> lat_timer_o == 8'h00;
  endproperty
  a_rev_out: assert property (p_rev_out)
    else $error("timer output nonzero in reverse mode");
  property p_base_lo; r50 |=> rdata_o[11:0] == 12'h000; endproperty
  a_base_lo: assert property (p_base_lo)
    else $error("base low bits not zero");
  property p_base_mask;
    r50 |=> (rdata_o[30:12] & ~$past(mem0_setup_i[30:12])) == 19'h0;
  endproperty
  a_base_mask: assert property (p_base_mask)
    else $error("masked base bits read nonzero");
  property p_excl; !(csr_hit_o && fwd_hit_o); endproperty
  a_excl: assert property (p_excl)
    else $error("both hits at once");
  property p_nohit; !mem_valid_i && ce_i |=> !csr_hit_o && !fwd_hit_o;
  endproperty
  a_nohit: assert property (p_nohit)
    else $error("hit without access");
endmodule

// *** verif/scfg_regs_bench.sv ***
// Purpose: Self-checking bench for scfg_regs
// Assumes: ce_i low only in the hold scenario
// Notes:   Scenario tasks judge their own results
`timescale 1ns/1ps
module scfg_regs_bench;
  logic        clk_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        resetn_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        fwd_bridge_i = 1'b1;
  logic        ext_mode_i = 1'b1;
  logic        mem_valid_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] mem0_setup_i = 32'h0;
  logic [31:0] mem0_xlat_i = 32'h0;
  logic [31:0] mem_addr_i = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] fwd_addr_o;
  logic        csr_hit_o;
  logic        fwd_hit_o;
  logic [8:0]  prio_o;
  logic [3:0]  line_size_o;
  logic [7:0]  lat_timer_o;
  int          fails = 0;
  int          num_checks = 0;
  always #5 clk_i = ~clk_i;

  scfg_regs u_scfg_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fwd_bridge_i(fwd_bridge_i),
    .ext_mode_i(ext_mode_i), .mem0_setup_i(mem0_setup_i),
    .mem0_xlat_i(mem0_xlat_i), .mem_addr_i(mem_addr_i),
    .mem_valid_i(mem_valid_i), .csr_hit_o(csr_hit_o),
    .fwd_hit_o(fwd_hit_o), .fwd_addr_o(fwd_addr_o),
    .prio_o(prio_o), .line_size_o(line_size_o),
    .lat_timer_o(lat_timer_o)
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst(input logic fwd, input logic ext);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    fwd_bridge_i <= fwd;
    ext_mode_i <= ext;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask
  // Leaves the strobe up so a following access runs back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge clk_i);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o);
  endtask
  task automatic dec(input logic [31:0] a, input logic c, input logic f,
                     input logic [31:0] fa);
    @(posedge clk_i);
    wr_i <= 1'b0;
    mem_valid_i <= 1'b1;
    mem_addr_i <= a;
    @(posedge clk_i);
    mem_valid_i <= 1'b0;
    #1 chk("hits", {30'h0, c, f}, {30'h0, csr_hit_o, fwd_hit_o});
    if (f) chk("fwd_addr", fa, fwd_addr_o);
  endtask
  task automatic set_win(input logic [31:0] s, input logic [31:0] x);
    @(posedge clk_i);
    mem0_setup_i <= s;
    mem0_xlat_i <= x;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      rst(i != 2, i != 1);
      rd(8'h48, 32'h0040_0000, "prio_rst");
      rd(8'h4c, (i == 0) ? 32'h4000 : 32'h0, "line_rst");
      rd(8'h50, 32'h0, "base_rst");
      chk("prio_o", 32'h1, {23'h0, prio_o});
      chk("lat_timer_o", (i == 0) ? 32'h40 : 32'h0, {24'h0, lat_timer_o});
    end
    $display("t_reset done");
  endtask
  task automatic t_regs;
    rst(1'b1, 1'b1);
    wr(8'h48, 32'hffff_ffff);
    rd(8'h48, 32'h7fc0_0000, "prio_ones");
    chk("prio_o", 32'h1ff, {23'h0, prio_o});
    wr(8'h48, 32'h0);
    rd(8'h48, 32'h0, "prio_zero");
    for (int b = 2; b < 6; b++) begin
      wr(8'h4c, 32'h1 << b);
      rd(8'h4c, 32'h1 << b, "line_bit");
    end
    wr(8'h4c, 32'hffff_ffff);
    rd(8'h4c, 32'h0000_ff3c, "line_ones");
    chk("line_size_o", 32'hf, {28'h0, line_size_o});
    chk("lat_timer_o", 32'hff, {24'h0, lat_timer_o});
    @(posedge clk_i);
    fwd_bridge_i <= 1'b0;
    wr(8'h4c, 32'h0000_5a3c);
    rd(8'h4c, 32'h0000_003c, "lat_rev");
    chk("lat_timer_o", 32'h0, {24'h0, lat_timer_o});
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0, "unmapped");
    $display("t_regs done");
  endtask
  task automatic t_base;
    set_win(32'hfff0_0000, 32'habc0_0000);
    wr(8'h50, 32'hffff_ffff);
    rd(8'h50, 32'hfff0_0000, "base_mask");
    wr(8'h50, 32'h1230_0fff);
    rd(8'h50, 32'h1230_0000, "base_wr");
    dec(32'h1230_0010, 1'b1, 1'b0, 32'h0);
    dec(32'h1234_5678, 1'b0, 1'b1, 32'habc4_5678);
    dec(32'h1240_0000, 1'b0, 1'b0, 32'h0);
    set_win(32'h8000_0000, 32'h0);
    wr(8'h50, 32'hffff_ffff);
    rd(8'h50, 32'h8000_0000, "base_2g");
    dec(32'h8000_0abc, 1'b1, 1'b0, 32'h0);
    dec(32'hc000_0000, 1'b0, 1'b1, 32'h4000_0000);
    set_win(32'h0, 32'h0);
    wr(8'h50, 32'hffff_ffff);
    rd(8'h50, 32'h0, "base_off");
    $display("t_base done");
  endtask
  // A write strobe seen while the clock enable is low must be dropped
  task automatic t_hold;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(8'h48, 32'hffff_ffff);
    @(posedge clk_i);
    wr_i <= 1'b0;
    ce_i <= 1'b1;
    rd(8'h48, 32'h0, "prio_hold");
    chk("prio_o", 32'h0, {23'h0, prio_o});
    $display("t_hold done");
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    t_reset;
    t_regs;
    t_base;
    t_hold;
    print_verdict;
  end
  // Tests need about a hundred cycles; allow about twenty times that
  initial begin
    #20000;
    fails++;
    $display("Error watchdog expired");
    print_verdict;
  end
endmodule

bind scfg_regs scfg_regs_assertions u_scfg_regs_assertions (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .fwd_bridge_i(fwd_bridge_i), .mem0_setup_i(mem0_setup_i),
  .mem_valid_i(mem_valid_i), .csr_hit_o(csr_hit_o),
  .fwd_hit_o(fwd_hit_o), .lat_timer_o(lat_timer_o)
);
